// ===== src/pmch_consts.svh
// constants for the power module command handler
`ifndef PMCH_CONSTS_SVH
`define PMCH_CONSTS_SVH
// command codes
`define PMCH_CMD_ON_OFF_CONTROL 8'h01
`define PMCH_CMD_ON_OFF_CONFIG 8'h02
`define PMCH_CMD_OC_RESP 8'hE5
`define PMCH_CMD_UC_RESP 8'hE6
`define PMCH_CMD_AVG_OC 8'hE7
`define PMCH_CMD_AVG_UC 8'hE8
`define PMCH_CMD_ADV_OPT 8'hE9
`define PMCH_CMD_CAPTURE 8'hEA
`define PMCH_CMD_SAVED_IND 8'hEB
`define PMCH_CMD_PHASE 8'hF0
`define PMCH_CMD_CAPT_HANDLING 8'hF3
`define PMCH_CMD_FACTORY 8'hF4
`define PMCH_CMD_DRV_OV 8'hF5
`define PMCH_CMD_DRV_UV 8'hF6
`define PMCH_CMD_DRV_READ 8'hF7
`define PMCH_CMD_DRV_OV_RESP 8'hF8
`define PMCH_CMD_DRV_UV_RESP 8'hF9
`define PMCH_CMD_ACCESS 8'hFA
`define PMCH_CMD_PRIV_PASS 8'hFB
`define PMCH_CMD_PUB_PASS 8'hFC
`define PMCH_CMD_PROT_MASK 8'hFD
// on/off control codes
`define PMCH_OP_OFF_IMM 8'h04
`define PMCH_OP_OFF_SOFT 8'h44
`define PMCH_OP_ON_NOM 8'h84
`define PMCH_OP_ON_MLOW 8'h94
`define PMCH_OP_ON_MHIGH 8'hA4
// on/off configuration codes
`define PMCH_CFG_ALWAYS 8'h00
`define PMCH_CFG_PIN_SOFT 8'h16
`define PMCH_CFG_PIN_IMM 8'h17
`define PMCH_CFG_COMMAND 8'h1A
// reset values
`define PMCH_RST_OP 8'h04
`define PMCH_RST_CFG 8'h16
`define PMCH_RST_RESP 8'h80
`define PMCH_RST_AVG_OC 16'hDB20
`define PMCH_RST_AVG_UC 16'hDCE0
`define PMCH_RST_ADV_OPT 16'h0800
`define PMCH_RST_SAVED_IND 16'hFFFF
`define PMCH_RST_PHASE 8'h00
`define PMCH_RST_CAPT_HANDLING 8'h00
`define PMCH_RST_DRV_OV 16'hCB80
`define PMCH_RST_DRV_UV 16'hCA40
`define PMCH_RST_ACCESS 8'h01
`define PMCH_RST_PASS 16'h0000
`define PMCH_RST_PROT_MASK 16'hFFFF
// format field positions
`define PMCH_L11_EXP_MSB 15
`define PMCH_L11_EXP_LSB 11
`define PMCH_L11_MAN_MSB 10
`define PMCH_FIXED_EXP 5'sh13
// capture block
`define PMCH_CAPT_BYTES 32
`endif

// ===== src/pmch_pkg.sv
// types of the power module command handler
package pmch_pkg;
  // output state, gray along off -> on -> stopping
  typedef enum logic [1:0]
  {
    PMCH_OFF = 2'b00,
    PMCH_ON = 2'b01,
    PMCH_SOFT_STOP = 2'b11
  } pmch_state_t;
  // margin selection
  typedef enum logic [1:0]
  {
    PMCH_MARGIN_NOM = 2'b00,
    PMCH_MARGIN_LOW = 2'b01,
    PMCH_MARGIN_HIGH = 2'b10
  } pmch_margin_t;
endpackage : pmch_pkg

// ===== src/pmch_handler.sv
// command interpreter of the power module: settings store, on/off logic
`include "pmch_consts.svh"
module pmch_handler
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // command port from the serial front end (same clock)
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_send_byte,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [4:0] cmd_byte_idx,
  // answer
  output logic rsp_valid,
  output logic rsp_ack,
  output logic [15:0] rsp_rdata,
  // analog side
  input wire logic enable_pin,
  input wire logic [15:0] drive_supply_sample,
  input wire logic [255:0] capture_values,
  input wire logic soft_stop_done,
  // controls
  output logic output_enable,
  output logic soft_stop_active,
  output logic [1:0] margin_select,
  output logic settings_apply
);
  // *************************************
  // helpers
  // *************************************
  // linear-eleven exponent field
  function automatic logic [4:0] l11_exponent(input logic [15:0] w);
    l11_exponent = w[`PMCH_L11_EXP_MSB:`PMCH_L11_EXP_LSB];
  endfunction : l11_exponent
  // linear-eleven mantissa field
  function automatic logic [10:0] l11_mantissa(input logic [15:0] w);
    l11_mantissa = w[`PMCH_L11_MAN_MSB:0];
  endfunction : l11_mantissa

  // *************************************
  // pin synchroniser
  // *************************************
  logic en_meta_ff;
  logic en_sync_ff;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_meta_ff <= 1'b0;
      en_sync_ff <= 1'b0;
    end
    else
    begin
      en_meta_ff <= enable_pin;
      en_sync_ff <= en_meta_ff;
    end
  end
  logic [15:0] gate_drive_supply_meta_ff;
  logic [15:0] gate_drive_supply_sync_ff;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gate_drive_supply_meta_ff <= 16'h0000;
      gate_drive_supply_sync_ff <= 16'h0000;
    end
    else
    begin
      gate_drive_supply_meta_ff <= drive_supply_sample;
      gate_drive_supply_sync_ff <= gate_drive_supply_meta_ff;
    end
  end
  // a word may be caught mid-change, so it is only taken once it reads the same twice;
  // a reading that never settles keeps showing the last steady word
  logic [15:0] gate_drive_supply_prev_ff;
  logic [15:0] gate_drive_supply_hold_ff;
  wire gate_drive_supply_steady = gate_drive_supply_sync_ff == gate_drive_supply_prev_ff;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gate_drive_supply_prev_ff <= 16'h0000;
      gate_drive_supply_hold_ff <= 16'h0000;
    end
    else
    begin
      gate_drive_supply_prev_ff <= gate_drive_supply_sync_ff;
      if (gate_drive_supply_steady) gate_drive_supply_hold_ff <= gate_drive_supply_sync_ff;
    end
  end

  // *************************************
  // settings registers
  // *************************************
  logic [7:0] op_ff;
  logic [7:0] cfg_ff;
  logic [7:0] oc_resp_ff;
  logic [7:0] uc_resp_ff;
  logic [15:0] avg_oc_ff;
  logic [15:0] avg_uc_ff;
  logic [15:0] adv_opt_ff;
  logic [7:0] phase_ff;
  logic [7:0] capt_ctl_ff;
  logic [15:0] drv_ov_ff;
  logic [15:0] drv_uv_ff;
  logic [7:0] drv_ov_resp_ff;
  logic [7:0] drv_uv_resp_ff;
  logic [15:0] priv_pass_ff;
  logic [15:0] pub_pass_ff;
  logic [15:0] prot_mask_ff;

  // write decode; read-only and unknown codes never match
  wire wr = cmd_valid && cmd_write && !cmd_send_byte;
  wire factory = cmd_valid && cmd_send_byte && cmd_code == `PMCH_CMD_FACTORY;
  wire is_op_code = cmd_wdata[7:0] == `PMCH_OP_OFF_IMM || cmd_wdata[7:0] == `PMCH_OP_OFF_SOFT
    || cmd_wdata[7:0] == `PMCH_OP_ON_NOM || cmd_wdata[7:0] == `PMCH_OP_ON_MLOW
    || cmd_wdata[7:0] == `PMCH_OP_ON_MHIGH;
  wire is_cfg_code = cmd_wdata[7:0] == `PMCH_CFG_ALWAYS || cmd_wdata[7:0] == `PMCH_CFG_PIN_SOFT
    || cmd_wdata[7:0] == `PMCH_CFG_PIN_IMM || cmd_wdata[7:0] == `PMCH_CFG_COMMAND;
  wire wr_op = wr && cmd_code == `PMCH_CMD_ON_OFF_CONTROL && is_op_code;
  wire wr_cfg = wr && cmd_code == `PMCH_CMD_ON_OFF_CONFIG && is_cfg_code;

  // stored settings; factory reload wins over a write
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_ff <= `PMCH_RST_OP;
      cfg_ff <= `PMCH_RST_CFG;
      oc_resp_ff <= `PMCH_RST_RESP;
      uc_resp_ff <= `PMCH_RST_RESP;
      avg_oc_ff <= `PMCH_RST_AVG_OC;
      avg_uc_ff <= `PMCH_RST_AVG_UC;
      adv_opt_ff <= `PMCH_RST_ADV_OPT;
      phase_ff <= `PMCH_RST_PHASE;
      capt_ctl_ff <= `PMCH_RST_CAPT_HANDLING;
      drv_ov_ff <= `PMCH_RST_DRV_OV;
      drv_uv_ff <= `PMCH_RST_DRV_UV;
      drv_ov_resp_ff <= `PMCH_RST_RESP;
      drv_uv_resp_ff <= `PMCH_RST_RESP;
      priv_pass_ff <= `PMCH_RST_PASS;
      pub_pass_ff <= `PMCH_RST_PASS;
      prot_mask_ff <= `PMCH_RST_PROT_MASK;
    end
    else if (factory)
    begin
      op_ff <= `PMCH_RST_OP;
      cfg_ff <= `PMCH_RST_CFG;
      oc_resp_ff <= `PMCH_RST_RESP;
      uc_resp_ff <= `PMCH_RST_RESP;
      avg_oc_ff <= `PMCH_RST_AVG_OC;
      avg_uc_ff <= `PMCH_RST_AVG_UC;
      adv_opt_ff <= `PMCH_RST_ADV_OPT;
      phase_ff <= `PMCH_RST_PHASE;
      capt_ctl_ff <= `PMCH_RST_CAPT_HANDLING;
      drv_ov_ff <= `PMCH_RST_DRV_OV;
      drv_uv_ff <= `PMCH_RST_DRV_UV;
      drv_ov_resp_ff <= `PMCH_RST_RESP;
      drv_uv_resp_ff <= `PMCH_RST_RESP;
      priv_pass_ff <= `PMCH_RST_PASS;
      pub_pass_ff <= `PMCH_RST_PASS;
      prot_mask_ff <= `PMCH_RST_PROT_MASK;
    end
    else if (wr)
    begin
      if (wr_op) op_ff <= cmd_wdata[7:0];
      if (wr_cfg) cfg_ff <= cmd_wdata[7:0];
      if (cmd_code == `PMCH_CMD_OC_RESP) oc_resp_ff <= cmd_wdata[7:0];
      if (cmd_code == `PMCH_CMD_UC_RESP) uc_resp_ff <= cmd_wdata[7:0];
      if (cmd_code == `PMCH_CMD_AVG_OC) avg_oc_ff <= cmd_wdata;
      if (cmd_code == `PMCH_CMD_AVG_UC) avg_uc_ff <= cmd_wdata;
      if (cmd_code == `PMCH_CMD_ADV_OPT) adv_opt_ff <= cmd_wdata;
      if (cmd_code == `PMCH_CMD_PHASE) phase_ff <= cmd_wdata[7:0];
      if (cmd_code == `PMCH_CMD_CAPT_HANDLING) capt_ctl_ff <= cmd_wdata[7:0];
      if (cmd_code == `PMCH_CMD_DRV_OV) drv_ov_ff <= cmd_wdata;
      if (cmd_code == `PMCH_CMD_DRV_UV) drv_uv_ff <= cmd_wdata;
      if (cmd_code == `PMCH_CMD_DRV_OV_RESP) drv_ov_resp_ff <= cmd_wdata[7:0];
      if (cmd_code == `PMCH_CMD_DRV_UV_RESP) drv_uv_resp_ff <= cmd_wdata[7:0];
      if (cmd_code == `PMCH_CMD_PRIV_PASS) priv_pass_ff <= cmd_wdata;
      if (cmd_code == `PMCH_CMD_PUB_PASS) pub_pass_ff <= cmd_wdata;
      if (cmd_code == `PMCH_CMD_PROT_MASK) prot_mask_ff <= cmd_wdata;
    end
  end

  // *************************************
  // read mux and acceptance
  // *************************************
  // one 8-bit lane of the capture block, selected by byte index
  wire [7:0] capt_byte = capture_values[{cmd_byte_idx, 3'b000} +: 8];
  logic [15:0] rd_mux;
  logic known;
  logic writable;
  always_comb
  begin
    rd_mux = 16'h0000;
    known = 1'b1;
    writable = 1'b1;
    unique case (cmd_code)
      `PMCH_CMD_ON_OFF_CONTROL: rd_mux = {8'h00, op_ff};
      `PMCH_CMD_ON_OFF_CONFIG: rd_mux = {8'h00, cfg_ff};
      `PMCH_CMD_OC_RESP: rd_mux = {8'h00, oc_resp_ff};
      `PMCH_CMD_UC_RESP: rd_mux = {8'h00, uc_resp_ff};
      `PMCH_CMD_AVG_OC: rd_mux = avg_oc_ff;
      `PMCH_CMD_AVG_UC: rd_mux = avg_uc_ff;
      `PMCH_CMD_ADV_OPT: rd_mux = adv_opt_ff;
      `PMCH_CMD_CAPTURE:
      begin
        rd_mux = {8'h00, capt_byte};
        writable = 1'b0;
      end
      `PMCH_CMD_SAVED_IND:
      begin
        rd_mux = `PMCH_RST_SAVED_IND;
        writable = 1'b0;
      end
      `PMCH_CMD_PHASE: rd_mux = {8'h00, phase_ff};
      `PMCH_CMD_CAPT_HANDLING: rd_mux = {8'h00, capt_ctl_ff};
      `PMCH_CMD_DRV_OV: rd_mux = drv_ov_ff;
      `PMCH_CMD_DRV_UV: rd_mux = drv_uv_ff;
      `PMCH_CMD_DRV_READ:
      begin
        rd_mux = gate_drive_supply_hold_ff;
        writable = 1'b0;
      end
      `PMCH_CMD_DRV_OV_RESP: rd_mux = {8'h00, drv_ov_resp_ff};
      `PMCH_CMD_DRV_UV_RESP: rd_mux = {8'h00, drv_uv_resp_ff};
      `PMCH_CMD_ACCESS:
      begin
        rd_mux = {8'h00, `PMCH_RST_ACCESS};
        writable = 1'b0;
      end
      `PMCH_CMD_PRIV_PASS: rd_mux = priv_pass_ff;
      `PMCH_CMD_PUB_PASS: rd_mux = pub_pass_ff;
      `PMCH_CMD_PROT_MASK: rd_mux = prot_mask_ff;
      default: known = 1'b0;
    endcase
  end
  // acceptance: reads of known codes always, writes only to writable ones
  wire accept = cmd_send_byte ? (cmd_code == `PMCH_CMD_FACTORY)
    : cmd_write ? (known && writable && (cmd_code == `PMCH_CMD_ON_OFF_CONTROL ? is_op_code
    : cmd_code == `PMCH_CMD_ON_OFF_CONFIG ? is_cfg_code : 1'b1))
    : known;

  // answer one cycle after the request
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsp_valid <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_rdata <= 16'h0000;
    end
    else
    begin
      rsp_valid <= cmd_valid;
      rsp_ack <= cmd_valid && accept;
      rsp_rdata <= (cmd_valid && !cmd_write && !cmd_send_byte && known) ? rd_mux : 16'h0000;
    end
  end

  // *************************************
  // on/off control
  // *************************************
  // run request from the configured source
  wire op_on = op_ff[7];
  wire run_req = (cfg_ff == `PMCH_CFG_ALWAYS) ? 1'b1
    : (cfg_ff == `PMCH_CFG_COMMAND) ? op_on
    : en_sync_ff;
  // soft stop for pin soft option or control byte soft off
  wire stop_soft = (cfg_ff == `PMCH_CFG_PIN_SOFT) ? 1'b1
    : (cfg_ff == `PMCH_CFG_COMMAND) ? (op_ff == `PMCH_OP_OFF_SOFT) : 1'b0;
  wire [1:0] nxt_margin = (op_ff == `PMCH_OP_ON_MLOW) ? pmch_pkg::PMCH_MARGIN_LOW
    : (op_ff == `PMCH_OP_ON_MHIGH) ? pmch_pkg::PMCH_MARGIN_HIGH : pmch_pkg::PMCH_MARGIN_NOM;

  pmch_pkg::pmch_state_t state_ff;
  pmch_pkg::pmch_state_t nxt_state;
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      pmch_pkg::PMCH_OFF: if (run_req) nxt_state = pmch_pkg::PMCH_ON;
      pmch_pkg::PMCH_ON: if (!run_req) nxt_state = stop_soft ? pmch_pkg::PMCH_SOFT_STOP : pmch_pkg::PMCH_OFF;
      pmch_pkg::PMCH_SOFT_STOP: if (soft_stop_done) nxt_state = pmch_pkg::PMCH_OFF;
      default: nxt_state = pmch_pkg::PMCH_OFF;
    endcase
  end

  // state and registered controls; settings latch on each enable
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= pmch_pkg::PMCH_OFF;
      output_enable <= 1'b0;
      soft_stop_active <= 1'b0;
      margin_select <= pmch_pkg::PMCH_MARGIN_NOM;
      settings_apply <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      output_enable <= nxt_state == pmch_pkg::PMCH_ON || nxt_state == pmch_pkg::PMCH_SOFT_STOP;
      soft_stop_active <= nxt_state == pmch_pkg::PMCH_SOFT_STOP;
      margin_select <= nxt_margin;
      settings_apply <= state_ff == pmch_pkg::PMCH_OFF && nxt_state == pmch_pkg::PMCH_ON;
    end
  end

  // *************************************
  // checks
  // *************************************
  AST_ALWAYS_ON: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg_ff == `PMCH_CFG_ALWAYS && state_ff == pmch_pkg::PMCH_OFF) |=> output_enable)
    else $error("always-on configuration did not start");
  AST_IMM_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg_ff == `PMCH_CFG_PIN_IMM && state_ff == pmch_pkg::PMCH_ON && !en_sync_ff) |=> !output_enable)
    else $error("immediate off did not stop output");
  AST_SOFT_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg_ff == `PMCH_CFG_PIN_SOFT && state_ff == pmch_pkg::PMCH_ON && !en_sync_ff) |=> soft_stop_active)
    else $error("soft off not entered");
  AST_CMD_SRC: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg_ff == `PMCH_CFG_COMMAND && op_ff == `PMCH_OP_ON_NOM && state_ff == pmch_pkg::PMCH_OFF) |=> output_enable)
    else $error("control command did not start output");
  AST_MARGIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (op_ff == `PMCH_OP_ON_MHIGH) |=> margin_select == pmch_pkg::PMCH_MARGIN_HIGH)
    else $error("margin high not selected");
  AST_READ_ANS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmd_valid && !cmd_write && !cmd_send_byte && known) |=> rsp_valid && rsp_ack)
    else $error("read not answered");
  AST_RO_REJECT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmd_valid && cmd_write && !cmd_send_byte && cmd_code == `PMCH_CMD_ACCESS) |=> !rsp_ack)
    else $error("write to read-only accepted");
  AST_FACTORY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    factory |=> (avg_oc_ff == `PMCH_RST_AVG_OC && phase_ff == `PMCH_RST_PHASE && cfg_ff == `PMCH_RST_CFG))
    else $error("factory reload incomplete");
  AST_APPLY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    settings_apply |-> output_enable && !$past(output_enable))
    else $error("apply pulse without enable edge");
  AST_APPLY_ONCE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    settings_apply |=> !settings_apply)
    else $error("apply pulse longer than one cycle");
  AST_IMM_CTRL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg_ff == `PMCH_CFG_COMMAND && op_ff == `PMCH_OP_OFF_IMM && state_ff == pmch_pkg::PMCH_ON) |=> !output_enable)
    else $error("immediate off code did not stop output");
  AST_SOFT_CTRL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cfg_ff == `PMCH_CFG_COMMAND && op_ff == `PMCH_OP_OFF_SOFT && state_ff == pmch_pkg::PMCH_ON)
    |=> soft_stop_active)
    else $error("soft off code did not start soft stop");
  AST_MARGIN_LOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (op_ff == `PMCH_OP_ON_MLOW) |=> margin_select == pmch_pkg::PMCH_MARGIN_LOW)
    else $error("margin low not selected");
  AST_SB_REJECT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmd_valid && cmd_send_byte && cmd_code != `PMCH_CMD_FACTORY) |=> !rsp_ack)
    else $error("unknown send-byte accepted");
  AST_CAPT_RO: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmd_valid && cmd_write && !cmd_send_byte && cmd_code == `PMCH_CMD_CAPTURE) |=> !rsp_ack)
    else $error("write to capture block accepted");
  AST_BAD_OP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr && cmd_code == `PMCH_CMD_ON_OFF_CONTROL && !is_op_code) |=> $stable(op_ff))
    else $error("illegal control code stored");
  AST_BAD_CFG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr && cmd_code == `PMCH_CMD_ON_OFF_CONFIG && !is_cfg_code) |=> $stable(cfg_ff))
    else $error("illegal configuration code stored");
  AST_WR_NO_DATA: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cmd_valid && (cmd_write || cmd_send_byte)) |=> rsp_rdata == 16'h0000)
    else $error("write answered with data");
  AST_ONE_ANSWER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rsp_valid |-> $past(cmd_valid))
    else $error("answer without request");
  AST_RESP_RELOAD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    factory |=> (oc_resp_ff == `PMCH_RST_RESP && uc_resp_ff == `PMCH_RST_RESP))
    else $error("fault responses not reloaded");
  AST_L11_RELOAD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    factory |=> (l11_exponent(drv_ov_ff) == l11_exponent(`PMCH_RST_DRV_OV)
    && l11_mantissa(drv_ov_ff) == l11_mantissa(`PMCH_RST_DRV_OV)))
    else $error("drive supply limit fields not reloaded");
endmodule : pmch_handler

// ===== sim/pmch_host_model.sv
// host and analog-side partner model of the power module command handler
module pmch_host_model
#(
  parameter int READ_GAP = 2,
  parameter int WRITE_GAP = 5,
  parameter int RESTORE_GAP = 20
)
(
  // clock
  input wire logic ref_clk,
  // command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic cmd_send_byte,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  output logic [4:0] cmd_byte_idx,
  // answer
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_rdata,
  // analog side
  input wire logic soft_stop_active,
  output logic soft_stop_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // analog side: soft stop completion
  // ****************************************
  int stop_delay = 0;
  int stop_cnt = 0;
  // quiet levels at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_send_byte = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    cmd_byte_idx = 5'h00;
    soft_stop_done = 1'b0;
  end
  // ramp-down ends stop_delay + 1 cycles after soft_stop_active rises, so slow supplies can be mimicked
  always @(posedge ref_clk)
  begin
    stop_cnt <= soft_stop_active ? stop_cnt + 1 : 0;
    soft_stop_done <= soft_stop_active && (stop_cnt >= stop_delay);
  end
  // ****************************************
  // host side: one command with pacing
  // ****************************************
  task automatic issue(input logic w, input logic sb, input logic [7:0] code, input logic [15:0] wd,
    input logic [4:0] idx, output logic ack, output logic [15:0] rd);
    int i;
    int gap;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_send_byte <= sb;
    cmd_code <= code;
    cmd_wdata <= wd;
    cmd_byte_idx <= idx;
    @(posedge ref_clk);
    // released lines flip so stale data never looks valid
    cmd_valid <= 1'b0;
    cmd_write <= ~w;
    cmd_send_byte <= ~sb;
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
    cmd_byte_idx <= ~idx;
    ack = 1'bx;
    rd = 16'hxxxx;
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (rsp_valid === 1'b1)
      begin
        ack = rsp_ack;
        rd = rsp_rdata;
        break;
      end
      @(posedge ref_clk);
    end
    gap = sb ? RESTORE_GAP : (w ? WRITE_GAP : READ_GAP);
    repeat (gap) @(posedge ref_clk);
  endtask : issue
endmodule : pmch_host_model

// ===== sim/tb_power_module_command_handler.sv
// self-checking bench of the power module command handler
module tb_power_module_command_handler;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and instances
  // ****************************************
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, cmd_write, cmd_send_byte, rsp_valid, rsp_ack, soft_stop_done;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata;
  logic [4:0] cmd_byte_idx;
  logic enable_pin = 1'b0;
  logic [15:0] drive_supply_sample = 16'h0000;
  logic [255:0] capture_values;
  logic output_enable, soft_stop_active, settings_apply, got_ack;
  logic [1:0] margin_select;
  logic [15:0] got_rd;
  logic saw_soft = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  int n_apply = 0;
  // rows: write, code, data, ack, read data; unknown code 55h stands in for every unlisted code
  logic [47:0] rows [0:39] = '{48'h0020_0001_0016, 48'h0010_0001_0004, 48'h0E50_0001_0080, 48'h0E60_0001_0080,
    48'h0E70_0001_DB20, 48'h0E80_0001_DCE0, 48'h0E90_0001_0800, 48'h0EB0_0001_FFFF, 48'h0F00_0001_0000,
    48'h0F50_0001_CB80, 48'h0F60_0001_CA40, 48'h0F80_0001_0080, 48'h0F90_0001_0080, 48'h0FA0_0001_0001,
    48'h0FB0_0001_0000, 48'h0FC0_0001_0000, 48'h0FD0_0001_FFFF, 48'h0F30_0001_0000, 48'h1E77_FFF1_0000,
    48'h0E70_0001_7FFF, 48'h1E88_0001_0000, 48'h0E80_0001_8000, 48'h1F00_0031_0000, 48'h0F00_0001_0003,
    48'h1E60_0C01_0000, 48'h0E60_0001_00C0, 48'h1FD1_2341_0000, 48'h0FD0_0001_1234, 48'h1FA0_0020_0000,
    48'h0FA0_0001_0001, 48'h1EB0_0000_0000, 48'h0EB0_0001_FFFF, 48'h1F70_0000_0000, 48'h1EA0_0000_0000,
    48'h0550_0000_0000, 48'h1550_0000_0000, 48'h1020_0330_0000, 48'h0020_0001_0016, 48'h1010_0550_0000,
    48'h0010_0001_0004};
  // control codes: code, on flag in bit 4, margin in bits 1:0
  logic [15:0] ops [0:3] = '{16'h8410, 16'h9411, 16'hA412, 16'h0400};
  always #2.5 ref_clk = ~ref_clk;
  pmch_handler u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_send_byte(cmd_send_byte), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_byte_idx(cmd_byte_idx),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .enable_pin(enable_pin),
    .drive_supply_sample(drive_supply_sample), .capture_values(capture_values), .soft_stop_done(soft_stop_done),
    .output_enable(output_enable), .soft_stop_active(soft_stop_active), .margin_select(margin_select),
    .settings_apply(settings_apply));
  pmch_host_model u_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_send_byte(cmd_send_byte), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_byte_idx(cmd_byte_idx),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .soft_stop_active(soft_stop_active),
    .soft_stop_done(soft_stop_done));
  // count start-up pulses and note any soft stop
  always @(posedge ref_clk)
  begin
    if (settings_apply === 1'b1) n_apply <= n_apply + 1;
    if (soft_stop_active === 1'b1) saw_soft <= 1'b1;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic w, input logic sb, input logic [7:0] code, input logic [15:0] wd,
    input logic [4:0] idx, input logic ack, input logic [15:0] rd);
    u_host.issue(w, sb, code, wd, idx, got_ack, got_rd);
    check({15'h0000, got_ack}, {15'h0000, ack});
    check(got_rd, rd);
  endtask : cmd
  // bounded wait on output_enable (sel 0) or soft_stop_active (sel 1)
  task automatic wait_out(input logic sel, input logic v);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      #1;
      if ((sel ? soft_stop_active : output_enable) === v) break;
    end
    check({15'h0000, sel ? soft_stop_active : output_enable}, {15'h0000, v});
  endtask : wait_out
  task automatic set_pin(input logic v);
    @(posedge ref_clk);
    enable_pin <= v;
  endtask : set_pin
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    for (int i = 0; i < 32; i++) capture_values[8*i +: 8] = 8'hA0 + 8'(i);
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    // settings are written while the output is off
    foreach (rows[i])
      cmd(rows[i][44], 1'b0, rows[i][43:36], rows[i][35:20], 5'h00, rows[i][16], rows[i][15:0]);
    // capture block edges and the synchronised supply reading
    for (int i = 0; i < 32; i += 31)
      cmd(1'b0, 1'b0, 8'hEA, 16'h0000, 5'(i), 1'b1, 16'h00A0 + 16'(i));
    @(posedge ref_clk);
    drive_supply_sample <= 16'h5A3C;
    repeat (4) @(posedge ref_clk);
    cmd(1'b0, 1'b0, 8'hF7, 16'h0000, 5'h00, 1'b1, 16'h5A3C);
    // pin start and slow soft stop
    set_pin(1'b1);
    wait_out(1'b0, 1'b1);
    // the pulse is counted one edge after it shows
    @(posedge ref_clk);
    #1;
    check(16'(n_apply), 16'h0001);
    u_host.stop_delay = 12;
    set_pin(1'b0);
    wait_out(1'b1, 1'b1);
    check({15'h0000, output_enable}, 16'h0001);
    wait_out(1'b0, 1'b0);
    // pin start and immediate stop
    cmd(1'b1, 1'b0, 8'h02, 16'h0017, 5'h00, 1'b1, 16'h0000);
    set_pin(1'b1);
    wait_out(1'b0, 1'b1);
    saw_soft = 1'b0;
    set_pin(1'b0);
    wait_out(1'b0, 1'b0);
    check({15'h0000, saw_soft}, 16'h0000);
    // command mode: pin ignored, every control code
    cmd(1'b1, 1'b0, 8'h02, 16'h001A, 5'h00, 1'b1, 16'h0000);
    set_pin(1'b1);
    repeat (10) @(posedge ref_clk);
    check({15'h0000, output_enable}, 16'h0000);
    // a lone module is its own reference, so margin changes go straight to it
    for (int i = 0; i < 4; i++)
    begin
      cmd(1'b1, 1'b0, 8'h01, {8'h00, ops[i][15:8]}, 5'h00, 1'b1, 16'h0000);
      wait_out(1'b0, ops[i][4]);
      check({14'h0000, margin_select}, {14'h0000, ops[i][1:0]});
    end
    cmd(1'b1, 1'b0, 8'h01, 16'h0084, 5'h00, 1'b1, 16'h0000);
    wait_out(1'b0, 1'b1);
    cmd(1'b1, 1'b0, 8'h01, 16'h0044, 5'h00, 1'b1, 16'h0000);
    wait_out(1'b1, 1'b1);
    wait_out(1'b0, 1'b0);
    // always-on mode with pin low and control off
    set_pin(1'b0);
    cmd(1'b1, 1'b0, 8'h02, 16'h0000, 5'h00, 1'b1, 16'h0000);
    wait_out(1'b0, 1'b1);
    // factory reload; other send-byte codes refused
    cmd(1'b1, 1'b0, 8'hE7, 16'h1234, 5'h00, 1'b1, 16'h0000);
    cmd(1'b1, 1'b1, 8'h03, 16'h0000, 5'h00, 1'b0, 16'h0000);
    cmd(1'b1, 1'b1, 8'hF4, 16'h0000, 5'h00, 1'b1, 16'h0000);
    cmd(1'b0, 1'b0, 8'hE7, 16'h0000, 5'h00, 1'b1, 16'hDB20);
    cmd(1'b0, 1'b0, 8'h02, 16'h0000, 5'h00, 1'b1, 16'h0016);
    wait_out(1'b0, 1'b0);
    // reset in mid-run brings defaults back
    cmd(1'b1, 1'b0, 8'hE5, 16'h0011, 5'h00, 1'b1, 16'h0000);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    cmd(1'b0, 1'b0, 8'hE5, 16'h0000, 5'h00, 1'b1, 16'h0080);
    give_verdict();
  end
  // watchdog: far beyond the few hundred cycles the sequence needs
  initial
  begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule : tb_power_module_command_handler
